// ===== common/pbpc_pkg.sv
package pbpc_pkg;
    // host register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LOCK_STATUS = 8'h08;
    // control register fields
    localparam int CTRL_GO_PROTECT = 0;
    localparam int CTRL_LOCKDOWN = 1;
    localparam int CTRL_GROUP_LSB = 4;
    localparam int CTRL_GO_QUERY = 8;
    localparam int CTRL_BA_LSB = 16;
    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_INIT_DONE = 1;
    localparam int ST_LOCKED_DOWN = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_ATTEMPTS_LSB = 8;
    // device commands
    localparam logic [7:0] CMD_ENTRY1 = 8'h4C;
    localparam logic [7:0] CMD_ENTRY2 = 8'h03;
    localparam logic [7:0] CMD_ENTRY3 = 8'h1D;
    localparam logic [7:0] CMD_ENTRY4 = 8'h41;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_LOCK_QUERY = 8'h7A;
    localparam logic [7:0] ADDR_ZERO = 8'h00;
    // lock status byte
    localparam logic [7:0] LOCK_STATUS_RST = 8'h0E;
    localparam int LOCK_ST_LOCKDOWN = 4;
    localparam int LOCK_ST_UNPROT = 3;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_PWRUP_US = 100;
    localparam int T_INIT_BUSY_MAX_US = 2000;
    localparam int T_WB_NS = 100;
    localparam int PWRUP_CYC = (T_PWRUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_BUSY_CYC = T_INIT_BUSY_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LO_CYC = 2;
    localparam int WE_HI_CYC = 2;
    localparam int RE_LO_CYC = 5;
    localparam int RE_HI_CYC = 2;
    localparam int CNT_W = 18;

    typedef enum logic [1:0] {
        PBPC_OP_INIT = 2'b00,
        PBPC_OP_PROTECT = 2'b01,
        PBPC_OP_QUERY = 2'b10
    } pbpc_op_t;

    typedef enum logic [2:0] {
        PBPC_K_CMD = 3'b000,
        PBPC_K_ADDR = 3'b001,
        PBPC_K_READ = 3'b010,
        PBPC_K_WAITRB = 3'b011,
        PBPC_K_DELAY = 3'b100,
        PBPC_K_END = 3'b101
    } pbpc_kind_t;

    typedef struct packed {
        pbpc_kind_t kind;
        logic [7:0] data;
    } pbpc_item_t;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic io_oe;
        logic [7:0] io_o;
    } pbpc_pins_t;
endpackage

// ===== hw/pbpc_host.sv
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// R1 - device protects sixteen four-block groups
// R2 - device ships with no group protected
// R3 - protected groups never return unprotected
// R4 - protect allowed until lockdown, then refused
// R5 - protect: 4C 03 1D 41 80, addresses, 10
// R6 - lockdown variant puts 1Y in address four
// R7 - exit every protect sequence with FFh
// R8 - group n covers blocks 4n to 4n+3
// R9 - never reset during protect programming busy; the host still sends FFh once the ready/busy poll times out
// R10 - at most sixteen protect attempts in total
// R11 - query: 7Ah, three addresses, one byte
// R12 - query block address split over three cycles
// R13 - bit 3 low means permanently protected
// R14 - bit 2 low means volatile locked
// R15 - bits 1 and 0 show volatile lockdown
// R16 - permanent lockdown bit, upper bits zero
// R17 - ready/busy valid within 100 us
// R18 - first command after power-up is FFh
// R19 - initialization busy lasts at most 2 ms
// R20 - only 70h accepted during init busy
// R21 - shared enable uses enhanced status read
// R22 - after init device sits in read setup
// R23 - hold write protect low during power-up
// R24 - ready/busy low while operation runs
// R25 - protected blocks unchanged by program/erase
module pbpc_host
    import pbpc_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC,
    parameter int BUSY_TIMEOUT_CYCLES = INIT_BUSY_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output pbpc_pkg::pbpc_pins_t nand_pins,
    input wire logic [7:0] nand_io_i,
    input wire logic ready_busy_out
);
    import pbpc_pkg::*;

    typedef enum logic [3:0] {
        PBPC_S_IDLE = 4'b0000,
        PBPC_S_FETCH = 4'b0001,
        PBPC_S_WR_LO = 4'b0010,
        PBPC_S_WR_HI = 4'b0011,
        PBPC_S_RD_LO = 4'b0100,
        PBPC_S_RD_HI = 4'b0101,
        PBPC_S_WB = 4'b0110,
        PBPC_S_POLL = 4'b0111,
        PBPC_S_DELAY = 4'b1000
    } pbpc_state_t;

    // sequence tables
    function automatic pbpc_item_t seq_item(pbpc_op_t op, logic [3:0] idx, logic lock,
                                            logic [3:0] grp, logic [11:0] ba);
        pbpc_item_t it;
        unique case (op)
            PBPC_OP_INIT: begin
                unique case (idx)
                    4'h0: it = '{kind: PBPC_K_DELAY, data: ADDR_ZERO}; // R17
                    4'h1: it = '{kind: PBPC_K_CMD, data: CMD_RESET}; // R18
                    4'h2: it = '{kind: PBPC_K_WAITRB, data: ADDR_ZERO}; // R19 R20
                    default: it = '{kind: PBPC_K_END, data: ADDR_ZERO};
                endcase
            end
            PBPC_OP_PROTECT: begin
                unique case (idx)
                    4'h0: it = '{kind: PBPC_K_CMD, data: CMD_ENTRY1}; // R5
                    4'h1: it = '{kind: PBPC_K_CMD, data: CMD_ENTRY2}; // R5
                    4'h2: it = '{kind: PBPC_K_CMD, data: CMD_ENTRY3}; // R5
                    4'h3: it = '{kind: PBPC_K_CMD, data: CMD_ENTRY4}; // R5
                    4'h4: it = '{kind: PBPC_K_CMD, data: CMD_PROG_SETUP}; // R5
                    4'h5, 4'h6, 4'h7, 4'h9: it = '{kind: PBPC_K_ADDR, data: ADDR_ZERO}; // R5
                    4'h8: it = '{kind: PBPC_K_ADDR, data: {3'b000, lock, grp}}; // R6 R8
                    4'hA: it = '{kind: PBPC_K_CMD, data: CMD_PROG_CONFIRM}; // R5
                    4'hB: it = '{kind: PBPC_K_WAITRB, data: ADDR_ZERO}; // R9 R24
                    4'hC: it = '{kind: PBPC_K_CMD, data: CMD_RESET}; // R7
                    4'hD: it = '{kind: PBPC_K_WAITRB, data: ADDR_ZERO}; // R7
                    default: it = '{kind: PBPC_K_END, data: ADDR_ZERO};
                endcase
            end
            default: begin
                unique case (idx)
                    4'h0: it = '{kind: PBPC_K_CMD, data: CMD_LOCK_QUERY}; // R11
                    4'h1: it = '{kind: PBPC_K_ADDR, data: {ba[1:0], 6'h00}}; // R12
                    4'h2: it = '{kind: PBPC_K_ADDR, data: ba[9:2]}; // R12
                    4'h3: it = '{kind: PBPC_K_ADDR, data: {6'h00, ba[11:10]}}; // R12
                    4'h4: it = '{kind: PBPC_K_READ, data: ADDR_ZERO}; // R11
                    default: it = '{kind: PBPC_K_END, data: ADDR_ZERO};
                endcase
            end
        endcase
        return it;
    endfunction

    pbpc_state_t state_q, state_d;
    pbpc_op_t op_q, op_d;
    logic [3:0] idx_q, idx_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    pbpc_pins_t pins_q, pins_d;
    logic lock_q, lock_d;
    logic [3:0] grp_q, grp_d;
    logic [11:0] ba_q, ba_d;
    logic init_done_q, init_done_d;
    logic locked_down_q, locked_down_d;
    logic refused_q, refused_d;
    logic timeout_q, timeout_d;
    logic [4:0] attempts_q, attempts_d;
    logic [7:0] lock_status_q, lock_status_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [1:0] rb_sync_q, rb_sync_d;
    logic [7:0] io_s1_q, io_s1_d;
    logic [7:0] io_s2_q, io_s2_d;
    pbpc_item_t item;
    logic [31:0] ctrl_view;
    logic [31:0] status_view;
    logic go_protect;
    logic go_query;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        pins_d = pins_q;
        lock_d = lock_q;
        grp_d = grp_q;
        ba_d = ba_q;
        init_done_d = init_done_q;
        locked_down_d = locked_down_q;
        refused_d = refused_q;
        timeout_d = timeout_q;
        attempts_d = attempts_q;
        lock_status_d = lock_status_q;
        rb_sync_d = {rb_sync_q[0], ready_busy_out};
        io_s1_d = nand_io_i;
        io_s2_d = io_s1_q;
        item = seq_item(op_q, idx_q, lock_q, grp_q, ba_q);
        ctrl_view = 32'h0000_0000;
        ctrl_view[CTRL_LOCKDOWN] = lock_q;
        ctrl_view[CTRL_GROUP_LSB +: 4] = grp_q;
        ctrl_view[CTRL_BA_LSB +: 12] = ba_q;
        status_view = 32'h0000_0000;
        status_view[ST_BUSY] = (state_q != PBPC_S_IDLE);
        status_view[ST_INIT_DONE] = init_done_q;
        status_view[ST_LOCKED_DOWN] = locked_down_q;
        status_view[ST_REFUSED] = refused_q;
        status_view[ST_TIMEOUT] = timeout_q;
        status_view[ST_ATTEMPTS_LSB +: 5] = attempts_q;
        // bus slave
        wr_pend_d = hsel && htrans[1] && hready && hwrite;
        addr_d = wr_pend_d ? haddr[7:0] : addr_q;
        hrdata_d = hrdata_q;
        if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL: hrdata_d = ctrl_view;
                OFS_STATUS: hrdata_d = status_view;
                OFS_LOCK_STATUS: hrdata_d = {24'h00_0000, lock_status_q};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
        go_protect = wr_pend_q && (addr_q == OFS_CTRL) && hwdata[CTRL_GO_PROTECT];
        go_query = wr_pend_q && (addr_q == OFS_CTRL) && hwdata[CTRL_GO_QUERY]
                   && !hwdata[CTRL_GO_PROTECT];
        if (wr_pend_q && (addr_q == OFS_STATUS)) begin
            refused_d = refused_q && !hwdata[ST_REFUSED];
            timeout_d = timeout_q && !hwdata[ST_TIMEOUT];
        end
        // fields feed the running sequence, so they only change while idle
        if (wr_pend_q && (addr_q == OFS_CTRL) && (state_q == PBPC_S_IDLE)) begin
            lock_d = hwdata[CTRL_LOCKDOWN];
            grp_d = hwdata[CTRL_GROUP_LSB +: 4];
            ba_d = hwdata[CTRL_BA_LSB +: 12];
        end
        if ((go_protect || go_query) && (state_q != PBPC_S_IDLE)) begin
            refused_d = 1'b1;
        end
        unique case (state_q)
            PBPC_S_IDLE: begin
                pins_d.ce_n = 1'b1;
                pins_d.io_oe = 1'b0;
                if (go_protect) begin
                    if (!init_done_q || locked_down_q || attempts_q == MAX_ATTEMPTS) begin
                        refused_d = 1'b1; // R4 R10
                    end else begin
                        op_d = PBPC_OP_PROTECT;
                        idx_d = 4'h0;
                        state_d = PBPC_S_FETCH;
                    end
                end else if (go_query) begin
                    if (!init_done_q) begin
                        refused_d = 1'b1; // R20
                    end else begin
                        op_d = PBPC_OP_QUERY;
                        idx_d = 4'h0;
                        state_d = PBPC_S_FETCH;
                    end
                end
            end
            PBPC_S_FETCH: begin
                pins_d.ce_n = 1'b0;
                cnt_d = '0;
                unique case (item.kind)
                    PBPC_K_CMD, PBPC_K_ADDR: begin
                        pins_d.cle = (item.kind == PBPC_K_CMD);
                        pins_d.ale = (item.kind == PBPC_K_ADDR);
                        pins_d.we_n = 1'b0;
                        pins_d.io_oe = 1'b1;
                        pins_d.io_o = item.data;
                        state_d = PBPC_S_WR_LO;
                    end
                    PBPC_K_READ: begin
                        pins_d.re_n = 1'b0;
                        state_d = PBPC_S_RD_LO;
                    end
                    PBPC_K_WAITRB: state_d = PBPC_S_WB;
                    PBPC_K_DELAY: begin
                        pins_d.ce_n = 1'b1;
                        state_d = PBPC_S_DELAY;
                    end
                    default: begin
                        pins_d.ce_n = 1'b1;
                        state_d = PBPC_S_IDLE;
                        if (op_q == PBPC_OP_INIT) begin
                            init_done_d = 1'b1;
                            pins_d.wp_n = 1'b1; // R23
                        end
                        if (op_q == PBPC_OP_PROTECT) begin
                            attempts_d = attempts_q + 5'h01; // R10
                            if (lock_q) begin
                                locked_down_d = 1'b1; // R4 R6
                            end
                        end
                    end
                endcase
            end
            PBPC_S_WR_LO: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WE_LO_CYC - 1)) begin
                    pins_d.we_n = 1'b1;
                    cnt_d = '0;
                    state_d = PBPC_S_WR_HI;
                end
            end
            PBPC_S_WR_HI: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WE_HI_CYC - 1)) begin
                    pins_d.cle = 1'b0;
                    pins_d.ale = 1'b0;
                    pins_d.io_oe = 1'b0;
                    idx_d = idx_q + 4'h1;
                    state_d = PBPC_S_FETCH;
                end
            end
            PBPC_S_RD_LO: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RE_LO_CYC - 1)) begin
                    lock_status_d = io_s2_q; // R11 R13 R14 R15 R16
                    pins_d.re_n = 1'b1;
                    cnt_d = '0;
                    state_d = PBPC_S_RD_HI;
                end
            end
            PBPC_S_RD_HI: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RE_HI_CYC - 1)) begin
                    idx_d = idx_q + 4'h1;
                    state_d = PBPC_S_FETCH;
                end
            end
            PBPC_S_WB: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WB_CYC - 1)) begin
                    cnt_d = '0;
                    state_d = PBPC_S_POLL;
                end
            end
            PBPC_S_POLL: begin
                cnt_d = cnt_q + 1'b1;
                if (rb_sync_q[1]) begin
                    idx_d = idx_q + 4'h1; // R21 R24
                    state_d = PBPC_S_FETCH;
                end else if (cnt_q == CNT_W'(BUSY_TIMEOUT_CYCLES - 1)) begin
                    timeout_d = 1'b1; // R19
                    idx_d = idx_q + 4'h1;
                    state_d = PBPC_S_FETCH;
                end
            end
            PBPC_S_DELAY: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(PWRUP_CYCLES - 1)) begin
                    idx_d = idx_q + 4'h1; // R17
                    state_d = PBPC_S_FETCH;
                end
            end
            default: state_d = PBPC_S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= PBPC_S_FETCH;
            op_q <= PBPC_OP_INIT;
            idx_q <= 4'h0;
            cnt_q <= '0;
            pins_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                        wp_n: 1'b0, io_oe: 1'b0, io_o: 8'h00};
            lock_q <= 1'b0;
            grp_q <= 4'h0;
            ba_q <= 12'h000;
            init_done_q <= 1'b0;
            locked_down_q <= 1'b0;
            refused_q <= 1'b0;
            timeout_q <= 1'b0;
            attempts_q <= 5'h00;
            lock_status_q <= LOCK_STATUS_RST;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            rb_sync_q <= 2'b00;
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            lock_q <= lock_d;
            grp_q <= grp_d;
            ba_q <= ba_d;
            init_done_q <= init_done_d;
            locked_down_q <= locked_down_d;
            refused_q <= refused_d;
            timeout_q <= timeout_d;
            attempts_q <= attempts_d;
            lock_status_q <= lock_status_d;
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            hrdata_q <= hrdata_d;
            rb_sync_q <= rb_sync_d;
            io_s1_q <= io_s1_d;
            io_s2_q <= io_s2_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign nand_pins = pins_q;
endmodule // pbpc_host

// ===== sim/pbpc_host_properties.sv
`timescale 1ns/1ns
module pbpc_host_properties
    import pbpc_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pbpc_pkg::pbpc_pins_t nand_pins,
    input wire logic ready_busy_out
);
    typedef struct packed {
        logic we, ce, re, first, pmode, qmode, exit;
        logic [7:0] last;
        logic [2:0] acnt;
        logic [1:0] rd;
        logic [4:0] conf;
    } pbpc_chk_t;
    pbpc_chk_t s_q, s_d;
    int cyc_q, cyc_d;
    logic cmd, adr;
    assign cmd = nand_pins.we_n && !s_q.we && nand_pins.cle;
    assign adr = nand_pins.we_n && !s_q.we && nand_pins.ale;
    // link tracker
    always_comb begin
        s_d = s_q;
        s_d.we = nand_pins.we_n;
        s_d.ce = nand_pins.ce_n;
        s_d.re = nand_pins.re_n;
        cyc_d = (cyc_q < PWRUP_CYCLES) ? cyc_q + 1 : cyc_q;
        if (cmd) begin
            s_d.first = 1'b1;
            s_d.last = nand_pins.io_o;
            s_d.acnt = 3'h0;
            s_d.rd = 2'h0;
            s_d.exit = (nand_pins.io_o == CMD_PROG_CONFIRM);
            if (nand_pins.io_o == CMD_PROG_SETUP) s_d.pmode = 1'b1;
            if (nand_pins.io_o == CMD_RESET) s_d.pmode = 1'b0;
            if (nand_pins.io_o == CMD_LOCK_QUERY) s_d.qmode = 1'b1;
            if (s_d.exit && s_q.conf != 5'h1F) s_d.conf = s_q.conf + 5'h1;
        end
        if (adr) s_d.acnt = s_q.acnt + 3'h1;
        if (!nand_pins.re_n && s_q.re) s_d.rd = s_q.rd + 2'h1;
        if (nand_pins.ce_n && !s_q.ce) s_d.qmode = 1'b0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{we: 1'b1, ce: 1'b1, re: 1'b1, default: '0};
            cyc_q <= 0;
        end else begin
            s_q <= s_d;
            cyc_q <= cyc_d;
        end
    end
    function automatic logic prev_ok(logic [7:0] b, logic [7:0] p);
        case (b)
            CMD_ENTRY2: return p == CMD_ENTRY1;
            CMD_ENTRY3: return p == CMD_ENTRY2;
            CMD_ENTRY4: return p == CMD_ENTRY3;
            CMD_PROG_SETUP: return p == CMD_ENTRY4;
            default: return 1'b1;
        endcase
    endfunction
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_strobe;
        !nand_pins.we_n && nand_pins.io_oe && $stable(nand_pins.io_o)
            ##1 nand_pins.we_n && $stable(nand_pins.io_o);
    endsequence
    a_powerup_quiet: assert property (cyc_q < PWRUP_CYCLES - 2 |-> nand_pins.ce_n && !nand_pins.wp_n)
        else $error("early link activity");
    a_first_reset: assert property (cmd && !s_q.first |-> nand_pins.io_o == CMD_RESET)
        else $error("first command not reset");
    a_entry_order: assert property (cmd |-> prev_ok(nand_pins.io_o, s_q.last))
        else $error("entry order");
    a_confirm_after_addr: assert property (cmd && nand_pins.io_o == CMD_PROG_CONFIRM |-> s_q.pmode && s_q.acnt == 3'h5)
        else $error("confirm too early");
    a_prot_addr_fmt: assert property (adr && s_q.pmode |-> (s_q.acnt == 3'h3) ? nand_pins.io_o[7:5] == 3'h0 : nand_pins.io_o == ADDR_ZERO)
        else $error("bad protect address");
    a_exit_by_reset: assert property (cmd && s_q.exit |-> nand_pins.io_o == CMD_RESET)
        else $error("no reset exit");
    a_ready_before_cmd: assert property ($fell(nand_pins.we_n) |-> ready_busy_out [*2])
        else $error("write while busy");
    a_query_addr_lines: assert property (adr && s_q.qmode |-> (s_q.acnt != 3'h0 || nand_pins.io_o[5:0] == 6'h00) && (s_q.acnt != 3'h2 || nand_pins.io_o[7:2] == 6'h00))
        else $error("bad query address");
    a_query_one_read: assert property ($rose(nand_pins.ce_n) && s_q.qmode |-> s_q.rd == 2'h1 && s_q.acnt == 3'h3)
        else $error("bad query shape");
    a_attempt_limit: assert property (cmd && nand_pins.io_o == CMD_PROG_CONFIRM |-> s_q.conf < 5'h10)
        else $error("too many attempts");
    a_byte_strobe: assert property ($fell(nand_pins.we_n) |=> s_strobe)
        else $error("bad write strobe");
endmodule // pbpc_host_properties

bind pbpc_host pbpc_host_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_pbpc_host_properties (
    .hclk(hclk), .hresetn(hresetn), .nand_pins(nand_pins), .ready_busy_out(ready_busy_out)
);

// ===== sim/pbpc_nand_model.sv
`timescale 1ns/1ns
module pbpc_nand_model
    import pbpc_pkg::*;
#(
    parameter int INIT_NS = 1000,
    parameter int FAST_NS = 300,
    parameter int SLOW_NS = 2000
) (
    input wire pbpc_pkg::pbpc_pins_t pins,
    input wire logic [7:0] io_bus,
    input wire logic slow_mode,
    output logic [7:0] dev_o,
    output logic dev_oe,
    output logic busy
);
    logic [15:0] prot_q = 16'h0000;
    logic lock_q = 1'b0;
    logic up_q = 1'b0;
    logic rsetup_q = 1'b0;
    logic query_q = 1'b0;
    logic [3:0] step_q = 4'h0;
    logic [7:0] adr_q [0:4];
    int nadr_q = 0;
    initial begin
        dev_o = 8'h00;
        dev_oe = 1'b0;
        busy = 1'b0;
    end
    task automatic hold_busy(input int ns);
        busy = 1'b1;
        #(ns);
        busy = 1'b0;
    endtask
    function automatic logic [7:0] lock_byte();
        logic [11:0] ba;
        ba = {adr_q[2][1:0], adr_q[1], adr_q[0][7:6]};
        return {3'h0, lock_q, !(ba < 12'h040 && prot_q[ba[5:2]]), 3'b110};
    endfunction
    // busy blocks this process
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.cle && !up_q) begin
            if (io_bus == CMD_RESET) begin
                up_q = 1'b1;
                hold_busy(INIT_NS);
                rsetup_q = 1'b1;
            end
        end else if (!pins.ce_n && pins.cle) begin
            if (io_bus == CMD_PROG_SETUP || io_bus == CMD_LOCK_QUERY) nadr_q = 0;
            query_q = (io_bus == CMD_LOCK_QUERY);
            case (io_bus)
                CMD_ENTRY1: step_q = 4'h1;
                CMD_ENTRY2: step_q = (step_q == 4'h1) ? 4'h2 : 4'h0;
                CMD_ENTRY3: step_q = (step_q == 4'h2) ? 4'h3 : 4'h0;
                CMD_ENTRY4: step_q = (step_q == 4'h3) ? 4'h4 : 4'h0;
                CMD_PROG_SETUP: step_q = (step_q == 4'h4) ? 4'h5 : 4'h0;
                CMD_PROG_CONFIRM: begin
                    if (step_q == 4'h5 && nadr_q == 5) begin
                        if (!lock_q) begin
                            prot_q[adr_q[3][3:0]] = 1'b1;
                            lock_q = adr_q[3][4];
                        end
                        hold_busy(slow_mode ? SLOW_NS : FAST_NS);
                    end
                    step_q = 4'h0;
                end
                CMD_RESET: begin
                    step_q = 4'h0;
                    hold_busy(FAST_NS);
                end
                default: step_q = 4'h0;
            endcase
        end else if (!pins.ce_n && pins.ale && up_q) begin
            if (nadr_q < 5) adr_q[nadr_q] = io_bus;
            nadr_q++;
        end
    end
    always @(negedge pins.re_n) begin
        if (!pins.ce_n && query_q && nadr_q == 3) begin
            dev_o = lock_byte();
            dev_oe = 1'b1;
        end
    end
    always @(posedge pins.re_n or posedge pins.ce_n) dev_oe = 1'b0;
endmodule // pbpc_nand_model

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import pbpc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, dev_oe, busy;
    logic [31:0] hrdata;
    pbpc_pins_t nand_pins;
    logic [7:0] nand_io_i, dev_o;
    logic slow_mode = 1'b0;
    logic [7:0] idle_io = 8'h5A;
    int bad_count = 0;
    int comparisons = 0;
    always #5 hclk = ~hclk;
    assign nand_io_i = nand_pins.io_oe ? nand_pins.io_o : (dev_oe ? dev_o : idle_io);
    always @(negedge dev_oe) idle_io = ~dev_o;
    always @(negedge nand_pins.io_oe) idle_io = ~nand_pins.io_o;
    pbpc_host #(.PWRUP_CYCLES(20), .BUSY_TIMEOUT_CYCLES(300)) u_pbpc_host (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nand_pins(nand_pins),
        .nand_io_i(nand_io_i), .ready_busy_out(!busy)
    );
    pbpc_nand_model u_pbpc_nand_model (
        .pins(nand_pins), .io_bus(nand_io_i), .slow_mode(slow_mode),
        .dev_o(dev_o), .dev_oe(dev_oe), .busy(busy)
    );
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(v & m, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask
    task automatic wait_bit(input int b, input logic val);
        logic [31:0] v;
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, v);
            n++;
        end while (v[b] !== val && n < 3000);
        check({31'h0, v[b]}, {31'h0, val});
    endtask
    task automatic protect(input logic [3:0] g, input logic lk);
        wr(OFS_CTRL, 32'h1 | ({31'h0, lk} << CTRL_LOCKDOWN) | ({28'h0, g} << CTRL_GROUP_LSB));
        wait_bit(ST_BUSY, 1'b0);
    endtask
    task automatic query(input logic [11:0] ba, input logic [7:0] exp);
        wr(OFS_CTRL, (32'h1 << CTRL_GO_QUERY) | ({20'h0, ba} << CTRL_BA_LSB));
        wait_bit(ST_BUSY, 1'b0);
        rd_chk(OFS_LOCK_STATUS, 32'hFFFFFFFF, {24'h0, exp});
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(OFS_LOCK_STATUS, 32'hFFFFFFFF, {24'h0, LOCK_STATUS_RST});
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
        wr(OFS_CTRL, 32'h1);
        rd_chk(OFS_STATUS, 32'h1 << ST_REFUSED, 32'h1 << ST_REFUSED);
        wr(OFS_STATUS, 32'h1 << ST_REFUSED);
        rd_chk(OFS_STATUS, 32'h1 << ST_REFUSED, 32'h0);
        wait_bit(ST_INIT_DONE, 1'b1);
        query(12'h000, 8'h0E);
        for (int g = 0; g < 16; g++) begin
            slow_mode <= (g == 7);
            protect(g[3:0], g == 15);
            query({g[9:0], 2'h3}, (g == 15) ? 8'h16 : 8'h06);
            if (g < 15) query({g[9:0] + 10'h1, 2'h0}, 8'h0E);
        end
        rd_chk(OFS_STATUS, 32'h00001F1C, 32'h00001004);
        protect(4'h0, 1'b0);
        rd_chk(OFS_STATUS, 32'h00001F08, 32'h00001008);
        for (int g = 0; g < 16; g++) query({g[9:0], g[1:0]}, 8'h16);
        query(12'h040, 8'h1E);
        query(12'hFFF, 8'h1E);
        rd_chk(OFS_CTRL, 32'h00000101, 32'h0);
        print_verdict();
    end
    initial begin
        #400000;
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule // testbench
